/* File: cell_pkg.sv */
// constants, field layout and mode encodings of the configurable io cell
// assumes one 100 MHz clock and a plain strobe register port
// What this block does
// - input capture is a flip-flop or a latch, plus two direct input paths
// - flip-flop takes data on the rising edge; latch is transparent while gate high
// - output gate does pass, and, or, xor with either input optionally inverted
// - mux mode picks one of two outputs, selected by the output clock
// - input and output registers have their own clock, each invertible
// - fast capture latch is gated by the output clock input
// - early clock may drive the output clock, the input clock, or both
// - global set/clear forces each register to its configured value
// - no set or reset source reaches the registers except global set/clear and the unconfigured state
// - configured set/clear choice gives value after configuration and after each pulse
// - unused pad defaults to pull-up; may be pull-down, driven output or input
// - pull-up is on while configuration is in progress
// - line driver disable high releases line, low drives the input value
// - disable tied low makes the driver a plain buffer
// - undriven shared line keeps its last level; any driver or pull overrides
// - wired-and driver: low input pulls low, high input releases
// - wired or-and driver pulls low only when both inputs are low
package cell_pkg;

  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  localparam int CFG_CONFIGURED = 0;
  localparam int CFG_IN_LATCH = 1;
  localparam int CFG_IN_CLK_INV = 2;
  localparam int CFG_OUT_CLK_INV = 3;
  localparam int CFG_IN_EARLY = 4;
  localparam int CFG_OUT_EARLY = 5;
  localparam int CFG_IN_INIT = 6;
  localparam int CFG_OUT_INIT = 7;
  localparam int CFG_OUT_MUX = 8;
  localparam int CFG_GATE_OP_LO = 9;
  localparam int CFG_INV_A = 11;
  localparam int CFG_INV_B = 12;
  localparam int CFG_OUT_REGISTERED = 13;
  localparam int CFG_PAD_MODE_LO = 14;
  localparam int CFG_LINE_MODE_LO = 16;
  localparam int CFG_LINE_PULLUP = 18;
  localparam int CFG_FAST_CAPTURE = 19;
  localparam int CFG_USED_BITS = 20;

  localparam int ST_IN_REG = 0;
  localparam int ST_OUT_REG = 1;
  localparam int ST_FAST_REG = 2;
  localparam int ST_PAD_IN = 3;
  localparam int ST_LINE = 4;

  localparam int SYNC_PAD = 0;
  localparam int SYNC_IN_CLK = 1;
  localparam int SYNC_OUT_CLK = 2;
  localparam int SYNC_EARLY = 3;
  localparam int SYNC_GSC = 4;
  localparam int SYNC_COUNT = 5;

  typedef enum logic [1:0] {PAD_PULL_UP, PAD_PULL_DOWN, PAD_DRIVE, PAD_INPUT} pad_mode_type;
  typedef enum logic [1:0] {LINE_STANDARD, LINE_WIRED_AND, LINE_OR_AND, LINE_SPARE} line_mode_type;
  typedef enum logic [1:0] {GATE_PASS, GATE_AND, GATE_OR, GATE_XOR} gate_op_type;

endpackage : cell_pkg

/* File: line_driver.sv */
// one driver onto a shared horizontal line, in one of three modes
// assumes the caller resolves the line level from all drivers
module line_driver (
  input wire cell_pkg::line_mode_type mode,
  input wire logic data,
  input wire logic data_b,
  input wire logic line_disable,
  output logic drv_out,
  output logic drv_oe
);
  import cell_pkg::*;

  always_comb begin
    drv_out = 1'b0;
    drv_oe = 1'b0;
    case (mode)
      LINE_STANDARD: begin
        // disable tied low gives an always-driving buffer
        drv_out = data;
        drv_oe = ~line_disable;
      end
      LINE_WIRED_AND: begin
        drv_oe = ~data;
      end
      LINE_OR_AND: begin
        drv_oe = ~(data | data_b);
      end
      default: begin
        drv_oe = 1'b0;
      end
    endcase
  end

endmodule : line_driver

/* File: configurable_io_cell.sv */
// configurable io cell: pad, input capture, output gate/mux and line drivers
// assumes pad, cell clocks and global set/clear arrive unsynchronised from pins
module configurable_io_cell #(
  parameter int DRIVERS = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up_en,
  output logic pull_down_en,
  input wire logic in_clk,
  input wire logic out_clk,
  input wire logic early_clk,
  input wire logic global_set_clear,
  input wire logic out_a,
  input wire logic out_b,
  output logic direct_input_path_one,
  output logic direct_input_path_two,
  output logic input_capture,
  output logic fast_capture,
  input wire logic [DRIVERS-1:0] drv_data,
  input wire logic [DRIVERS-1:0] drv_data_b,
  input wire logic [DRIVERS-1:0] drv_disable,
  output logic line_level
);
  import cell_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic [31:0] cfg_reg;
  logic [31:0] rd_data_reg;
  logic [SYNC_COUNT-1:0] sync1_reg;
  logic [SYNC_COUNT-1:0] sync2_reg;
  logic in_lvl_prev_reg;
  logic out_lvl_prev_reg;
  logic in_reg;
  logic out_reg;
  logic fast_reg;
  logic pad_out_reg;
  logic pad_oe_reg;
  logic pull_up_reg;
  logic pull_down_reg;
  logic line_level_reg;

  logic configured;
  logic pad_s;
  logic gsc_s;
  logic in_lvl;
  logic out_lvl;
  logic in_edge;
  logic out_edge;
  logic gate_a;
  logic gate_b;
  logic gate_result;
  logic path_result;
  logic pad_out_next;
  logic line_next;
  logic any_low;
  logic any_high;
  pad_mode_type pad_mode;
  line_mode_type line_mode;
  gate_op_type gate_op;
  logic [DRIVERS-1:0] drv_out;
  logic [DRIVERS-1:0] drv_oe;

  assign configured = cfg_reg[CFG_CONFIGURED];
  assign pad_mode = pad_mode_type'(cfg_reg[CFG_PAD_MODE_LO +: 2]);
  assign line_mode = line_mode_type'(cfg_reg[CFG_LINE_MODE_LO +: 2]);
  assign gate_op = gate_op_type'(cfg_reg[CFG_GATE_OP_LO +: 2]);

  // register port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_strobe && addr == CFG_OFFSET) begin
      cfg_reg <= {{(32 - CFG_USED_BITS){1'b0}}, wr_data[CFG_USED_BITS-1:0]};
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (rd_strobe && addr == CFG_OFFSET) begin
      rd_data_reg <= cfg_reg;
    end else if (rd_strobe && addr == STATUS_OFFSET) begin
      rd_data_reg <= 32'h0000_0000;
      rd_data_reg[ST_IN_REG] <= in_reg;
      rd_data_reg[ST_OUT_REG] <= out_reg;
      rd_data_reg[ST_FAST_REG] <= fast_reg;
      rd_data_reg[ST_PAD_IN] <= pad_s;
      rd_data_reg[ST_LINE] <= line_level_reg;
    end else begin
      rd_data_reg <= 32'h0000_0000;
    end
  end

  assign rd_data = rd_data_reg;

  // pins and cell clocks come from outside this clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {global_set_clear, early_clk, out_clk, in_clk, pad_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign pad_s = sync2_reg[SYNC_PAD];
  assign gsc_s = sync2_reg[SYNC_GSC];

  // early clock can replace either cell clock; each clock invertible
  assign in_lvl = (cfg_reg[CFG_IN_EARLY] ? sync2_reg[SYNC_EARLY] : sync2_reg[SYNC_IN_CLK])
                  ^ cfg_reg[CFG_IN_CLK_INV];
  assign out_lvl = (cfg_reg[CFG_OUT_EARLY] ? sync2_reg[SYNC_EARLY] : sync2_reg[SYNC_OUT_CLK])
                   ^ cfg_reg[CFG_OUT_CLK_INV];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_lvl_prev_reg <= 1'b0;
      out_lvl_prev_reg <= 1'b0;
    end else begin
      in_lvl_prev_reg <= in_lvl;
      out_lvl_prev_reg <= out_lvl;
    end
  end

  // inverted clock turns a rising-edge register into a falling-edge one
  assign in_edge = in_lvl & ~in_lvl_prev_reg;
  assign out_edge = out_lvl & ~out_lvl_prev_reg;

  // input capture; only global set/clear and the unconfigured state force it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_reg <= 1'b0;
    end else if (!configured || gsc_s) begin
      in_reg <= cfg_reg[CFG_IN_INIT];
    end else if (cfg_reg[CFG_IN_LATCH]) begin
      if (in_lvl) begin
        in_reg <= pad_s;
      end
    end else if (in_edge) begin
      in_reg <= pad_s;
    end
  end

  // fast capture latch shares the output clock input rather than its own pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fast_reg <= 1'b0;
    end else if (!configured || gsc_s) begin
      fast_reg <= cfg_reg[CFG_IN_INIT];
    end else if (cfg_reg[CFG_FAST_CAPTURE] && out_lvl) begin
      fast_reg <= pad_s;
    end
  end

  assign direct_input_path_one = pad_s;
  assign direct_input_path_two = pad_s;
  assign input_capture = in_reg;
  assign fast_capture = fast_reg;

  // output gate with per-input inversion
  assign gate_a = out_a ^ cfg_reg[CFG_INV_A];
  assign gate_b = out_b ^ cfg_reg[CFG_INV_B];

  always_comb begin
    gate_result = gate_a;
    case (gate_op)
      GATE_PASS: gate_result = gate_a;
      GATE_AND: gate_result = gate_a & gate_b;
      GATE_OR: gate_result = gate_a | gate_b;
      GATE_XOR: gate_result = gate_a ^ gate_b;
      default: gate_result = gate_a;
    endcase
  end

  // mux mode time-shares the pad, the output clock acting as select
  assign path_result = cfg_reg[CFG_OUT_MUX] ? (out_lvl ? out_b : out_a) : gate_result;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= 1'b0;
    end else if (!configured || gsc_s) begin
      out_reg <= cfg_reg[CFG_OUT_INIT];
    end else if (out_edge) begin
      out_reg <= path_result;
    end
  end

  // the mux consumes the output clock as select, so it never goes through out_reg
  assign pad_out_next = (cfg_reg[CFG_OUT_REGISTERED] && !cfg_reg[CFG_OUT_MUX]) ? out_reg : path_result;

  // pad drive and pulls; pull-up holds until configuration completes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_out_reg <= 1'b0;
      pad_oe_reg <= 1'b0;
      pull_up_reg <= 1'b1;
      pull_down_reg <= 1'b0;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= configured && pad_mode == PAD_DRIVE;
      pull_up_reg <= !configured || pad_mode == PAD_PULL_UP;
      pull_down_reg <= configured && pad_mode == PAD_PULL_DOWN;
    end
  end

  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign pull_up_en = pull_up_reg;
  assign pull_down_en = pull_down_reg;

  // shared line drivers
  generate
    for (genvar i = 0; i < DRIVERS; i++) begin : g_drv
      line_driver u_drv (
        .mode(line_mode),
        .data(drv_data[i]),
        .data_b(drv_data_b[i]),
        .line_disable(drv_disable[i]),
        .drv_out(drv_out[i]),
        .drv_oe(drv_oe[i])
      );
    end
  endgenerate

  assign any_low = |(drv_oe & ~drv_out);
  assign any_high = |(drv_oe & drv_out);

  // low wins over high so contention shows up as a low line
  always_comb begin
    if (any_low) begin
      line_next = 1'b0;
    end else if (any_high || cfg_reg[CFG_LINE_PULLUP]) begin
      line_next = 1'b1;
    end else begin
      line_next = line_level_reg;
    end
  end

  // the keeper is this flop: it only changes when a driver or the line pull-up acts on the line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_level_reg <= 1'b1;
    end else begin
      line_level_reg <= line_next;
    end
  end

  assign line_level = line_level_reg;

  in_ff_capture_a: assert property (
    configured && !cfg_reg[CFG_IN_LATCH] && !gsc_s && in_edge |=> in_reg == $past(pad_s)
  ) else $error("input flip-flop missed its edge");

  in_ff_hold_a: assert property (
    configured && $past(configured) && !cfg_reg[CFG_IN_LATCH] && !gsc_s && !in_edge |=> $stable(in_reg)
  ) else $error("input flip-flop changed without an edge");

  in_latch_pass_a: assert property (
    configured && cfg_reg[CFG_IN_LATCH] && !gsc_s && in_lvl |=> in_reg == $past(pad_s)
  ) else $error("input latch not transparent while gate high");

  gsc_force_a: assert property (
    configured && gsc_s |=> in_reg == $past(cfg_reg[CFG_IN_INIT]) && out_reg == $past(cfg_reg[CFG_OUT_INIT])
  ) else $error("global set/clear did not force init values");

  preconfig_pull_a: assert property (
    !configured |=> pull_up_en && !pad_oe && !pull_down_en
  ) else $error("pull-up not active before configuration");

  gate_and_a: assert property (
    configured && !cfg_reg[CFG_OUT_MUX] && !cfg_reg[CFG_OUT_REGISTERED] && gate_op == GATE_AND
    && !cfg_reg[CFG_INV_A] && !cfg_reg[CFG_INV_B] |=> pad_out == ($past(out_a) & $past(out_b))
  ) else $error("and gate result wrong on pad");

  mux_select_a: assert property (
    configured && cfg_reg[CFG_OUT_MUX] |=> pad_out == ($past(out_lvl) ? $past(out_b) : $past(out_a))
  ) else $error("pad mux picked the wrong output");

  fast_latch_a: assert property (
    configured && !gsc_s && cfg_reg[CFG_FAST_CAPTURE] && !out_lvl |=> $stable(fast_reg)
  ) else $error("fast capture latch moved with its gate low");

  wired_low_a: assert property (
    line_mode == LINE_WIRED_AND && !(&drv_data) |=> !line_level
  ) else $error("wired-and line not pulled low");

  keeper_hold_a: assert property (
    drv_oe == '0 && !cfg_reg[CFG_LINE_PULLUP] |=> $stable(line_level)
  ) else $error("keeper lost the line level");

endmodule : configurable_io_cell

/* File: pad_pin_model.sv */
// board-side model of the package pin in front of the io cell
// assumes the bench chooses whether an outside source drives the pin
module pad_pin_model (
  input wire logic clk,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  input wire logic ext_en,
  input wire logic ext_val,
  output logic pad_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_reg = 1'b0;

  // a floating pin must not look stable, so it toggles
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  always_comb begin
    if (pad_oe) begin
      pad_level = pad_out;
    end else if (ext_en) begin
      pad_level = ext_val;
    end else if (pull_up_en) begin
      pad_level = 1'b1;
    end else if (pull_down_en) begin
      pad_level = 1'b0;
    end else begin
      pad_level = float_reg;
    end
  end
endmodule : pad_pin_model

/* File: tb.sv */
// self-checking bench for the configurable io cell
// assumes the pin model drives pad_in; the bench drives all else
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cell_pkg::*;
  logic clk = 0, rstn = 0, wr_strobe = 0, rd_strobe = 0, in_clk = 0, out_clk = 0;
  logic early_clk = 0, gsc = 0, out_a = 0, out_b = 0, ext_en = 0, ext_val = 0;
  logic pad_in, pad_out, pad_oe, pu, pd, p1, p2, cap, fcap, line;
  logic [7:0] addr = 0;
  logic [31:0] wr_data = 0, rd_data, v;
  logic [3:0] dd = 0, db = 0, dx = 4'hF;
  int fails = 0, n_tests = 0;

  configurable_io_cell #(.DRIVERS(4)) i_dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pu), .pull_down_en(pd),
    .in_clk(in_clk), .out_clk(out_clk), .early_clk(early_clk), .global_set_clear(gsc),
    .out_a(out_a), .out_b(out_b), .direct_input_path_one(p1), .direct_input_path_two(p2),
    .input_capture(cap), .fast_capture(fcap), .drv_data(dd), .drv_data_b(db),
    .drv_disable(dx), .line_level(line));

  pad_pin_model i_pin (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pu),
    .pull_down_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic results();
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 v = rd_data;
  endtask : rd

  task automatic pin(input bit e, input logic x);
    @(posedge clk);
    if (e) begin
      early_clk <= x;
    end else begin
      in_clk <= x;
    end
    w(6);
  endtask : pin

  task automatic t_regs();
    wr(CFG_OFFSET, 32'hFFF0_4000);
    w(6);
    chk("pull_up_en", 1, pu);
    rd(CFG_OFFSET);
    chk("cfg", 32'h0000_4000, v);
    wr(STATUS_OFFSET, 32'hFFFF_FFFF);
    rd(8'h08);
    chk("unmapped", 0, v);
  endtask : t_regs

  task automatic t_pad();
    wr(CFG_OFFSET, 32'h0000_0001);
    w(4);
    chk("pull_up_en", 1, pu);
    chk("pull_down_en", 0, pd);
    wr(CFG_OFFSET, 32'h0000_4001);
    w(6);
    chk("pull_up_en", 0, pu);
    chk("pull_down_en", 1, pd);
    chk("path_one", 0, p1);
    wr(CFG_OFFSET, 32'h0000_8001);
    w(2);
    chk("pad_oe", 1, pad_oe);
    wr(CFG_OFFSET, 32'h0000_C001);
    ext_en <= 1'b1;
    ext_val <= 1'b1;
    w(6);
    chk("pad_oe", 0, pad_oe);
    chk("path_one", 1, p1);
    chk("path_two", 1, p2);
  endtask : t_pad

  // unconfigured write first, so the register starts from its init value
  task automatic ff(input logic [31:0] c, input bit e, input logic i);
    pin(e, i);
    ext_val <= 1'b0;
    wr(CFG_OFFSET, c ^ 32'h0000_0001);
    wr(CFG_OFFSET, c);
    w(6);
    ext_val <= 1'b1;
    w(6);
    chk("capture idle", 0, cap);
    pin(e, ~i);
    chk("capture edge", 1, cap);
    ext_val <= 1'b0;
    pin(e, i);
    chk("capture hold", 1, cap);
  endtask : ff

  task automatic t_latch();
    wr(CFG_OFFSET, 32'h0000_C003);
    pin(0, 1);
    ext_val <= 1'b1;
    w(6);
    chk("latch open", 1, cap);
    pin(0, 0);
    ext_val <= 1'b0;
    w(6);
    chk("latch shut", 1, cap);
    wr(CFG_OFFSET, 32'h0008_C001);
    out_clk <= 1'b1;
    w(6);
    chk("fast open", 0, fcap);
    ext_val <= 1'b1;
    w(6);
    chk("fast open", 1, fcap);
    out_clk <= 1'b0;
    w(6);
    ext_val <= 1'b0;
    w(6);
    chk("fast shut", 1, fcap);
  endtask : t_latch

  task automatic t_gsc(input logic [31:0] c, input logic e);
    wr(CFG_OFFSET, c ^ 32'h0000_0001);
    ext_val <= !e;
    w(2);
    chk("init", e, cap);
    wr(CFG_OFFSET, c);
    pin(0, 1);
    chk("capture pre", !e, cap);
    gsc <= 1'b1;
    w(6);
    chk("gsc in", e, cap);
    rd(STATUS_OFFSET);
    chk("gsc out", e, v[ST_OUT_REG]);
    w(1);
    gsc <= 1'b0;
    pin(0, 0);
  endtask : t_gsc

  task automatic t_gate();
    logic x, y, e;
    for (int k = 0; k < 64; k++) begin
      if (k % 4 == 0) begin
        wr(CFG_OFFSET, 32'h0000_8001 | ((k >> 2) << 9));
      end
      out_a <= k[0];
      out_b <= k[1];
      w(3);
      x = k[0] ^ k[4];
      y = k[1] ^ k[5];
      e = (k[3:2] == 0) ? x : (k[3:2] == 1) ? x & y : (k[3:2] == 2) ? x | y : x ^ y;
      chk("gate", e, pad_out);
    end
  endtask : t_gate

  task automatic t_mux();
    wr(CFG_OFFSET, 32'h0000_8101);
    out_a <= 1'b1;
    out_b <= 1'b0;
    w(6);
    chk("mux sel a", 1, pad_out);
    out_clk <= 1'b1;
    w(6);
    chk("mux sel b", 0, pad_out);
    out_a <= 1'b0;
    out_b <= 1'b1;
    w(3);
    chk("mux swap", 1, pad_out);
    wr(CFG_OFFSET, 32'h0000_A021);
    out_a <= 1'b1;
    out_clk <= 1'b0;
    w(6);
    chk("oreg idle", 0, pad_out);
    pin(1, 1);
    chk("oreg early", 1, pad_out);
  endtask : t_mux

  task automatic ln(input logic [3:0] d, input logic [3:0] b, input logic [3:0] x, input logic e);
    @(posedge clk);
    dd <= d;
    db <= b;
    dx <= x;
    w(3);
    chk("line_level", e, line);
  endtask : ln

  task automatic t_line();
    wr(CFG_OFFSET, 32'h0000_0001);
    ln(4'h1, 4'h0, 4'hE, 1);
    ln(4'h0, 4'h0, 4'h0, 0);
    ln(4'hF, 4'h0, 4'hF, 0);
    ln(4'h1, 4'h0, 4'hE, 1);
    ln(4'h0, 4'h0, 4'hF, 1);
    wr(CFG_OFFSET, 32'h0005_0001);
    ln(4'hF, 4'h0, 4'h0, 1);
    ln(4'hB, 4'h0, 4'hF, 0);
    wr(CFG_OFFSET, 32'h0006_0001);
    ln(4'h5, 4'hA, 4'h0, 1);
    ln(4'h4, 4'hA, 4'h0, 0);
    rd(STATUS_OFFSET);
    chk("status line", 0, v[ST_LINE]);
  endtask : t_line

  initial begin
    w(20);
    chk("pull_up_en", 1, pu);
    chk("line_level", 1, line);
    rstn <= 1'b1;
    t_regs();
    t_pad();
    ff(32'h0000_C001, 0, 0);
    ff(32'h0000_C005, 0, 1);
    ff(32'h0000_C011, 1, 0);
    t_latch();
    t_gsc(32'h0000_C0C1, 1);
    t_gsc(32'h0000_C001, 0);
    t_gate();
    t_mux();
    t_line();
    results();
  end

  // whole run is about six hundred cycles; this only catches a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
endmodule : tb
